// [rtl/ddfl_pkg.sv]
// Shared constants for the DLL switching, frequency change and write leveling device model.
// Assumes a 100 MHz system clock and pins sampled from a slower, unrelated link clock.
// Functional notes
// - Writing one to the DLL-disable bit puts device in DLL-off until cleared.
// - In self refresh past tCKSRE the device ignores the clock.
// - Power-down change: ODT low keeps termination off; disabled termination stays off.
// - In leveling, sample clock on rising strobe edge and return it on data.
// - In leveling device terminates strobes; controller terminates data bus.
// - Sixteen-bit device levels each byte lane from its own strobe pair.
// - Mode register 1 bit A7 one enters write leveling, zero leaves it.
// - DLL-off needs only CAS latency 6 and CAS write latency 6.
package ddfl_pkg;
  // Register byte offsets
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_ERR    = 5'h08;
  localparam logic [4:0] REG_MR0    = 5'h0C;
  localparam logic [4:0] REG_MR1    = 5'h10;
  localparam logic [4:0] REG_MR2    = 5'h14;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int CTRL_FB_ALL  = 0;
  localparam int CTRL_ERR_EN  = 1;
  // Mode register field positions
  localparam int MR1_DLL_OFF  = 0;
  localparam int MR1_WL       = 7;
  localparam int MR1_QOFF     = 12;
  localparam int MR0_DLL_RST  = 8;
  localparam logic [12:0] MR_RESET     = 13'h0000;
  localparam logic [12:0] MR1_RTT_MASK = 13'h0244;
  localparam logic [12:0] MR2_RTT_MASK = 13'h0600;
  localparam logic [12:0] MR0_CL_MASK  = 13'h0074;
  localparam logic [12:0] MR0_CL6      = 13'h0020;
  localparam logic [12:0] MR2_CWL_MASK = 13'h0038;
  localparam logic [12:0] MR2_CWL6     = 13'h0008;
  // Command codes {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TCKSRE_NS     = 10;
  localparam int TCKSRE_CYC    = (TCKSRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TDLLK_NCK     = 512;
  localparam int ERR_W         = 3;
  typedef enum logic [1:0] {ST_IDLE, ST_SELF_REF, ST_PWR_DN} ddfl_state_e;
endpackage

// [rtl/ddfl_sync.sv]
// Two-stage synchroniser for a bundle of pin levels.
// Assumes each bit is slow next to clk; bits may resolve one cycle apart.
`timescale 1ns/1ps
module ddfl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end
endmodule

// [rtl/ddfl_wl_lane.sv]
// One byte lane of write-leveling feedback.
// Assumes strobe and clock levels already synchronised to clk.
`timescale 1ns/1ps
module ddfl_wl_lane (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic strobe,
  input  wire logic ckLevel,
  input  wire logic enable,
  output logic      sample,
  output logic      strobeRise
);
  logic prevStrobe;
  logic next_sample;

  always_comb begin
    strobeRise  = strobe & ~prevStrobe;
    next_sample = sample;
    if (enable && strobeRise) begin
      next_sample = ckLevel;
    end else if (!enable) begin
      next_sample = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prevStrobe <= 1'b0;
      sample     <= 1'b0;
    end else begin
      prevStrobe <= strobe;
      sample     <= next_sample;
    end
  end
endmodule

// [rtl/ddfl_top.sv]
// Device-side mode, DLL, self refresh, power-down and write-leveling logic.
// Assumes the controller keeps its sequencing; pins arrive asynchronous to clk.
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module ddfl_top #(
  parameter int TDLLK = ddfl_pkg::TDLLK_NCK
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [4:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  input  wire logic [3:0]  avsByteenable,
  output logic      [31:0] avsReaddata,
  output logic             avsWaitrequest,
  input  wire logic        ck,
  input  wire logic        cke,
  input  wire logic        odt,
  input  wire logic        csN,
  input  wire logic        rasN,
  input  wire logic        casN,
  input  wire logic        weN,
  input  wire logic [2:0]  ba,
  input  wire logic [12:0] addr,
  input  wire logic        upperStrobePair,
  input  wire logic        lowerStrobePair,
  output logic      [15:0] dqOut,
  output logic             dqOeN,
  output logic             strobeTermOn,
  output logic             dqTermOn,
  output logic             dllLockedOut
);
  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [24:0] pinSync;
  logic ckS, ckeS, odtS, csNS, rasNS, casNS, weNS, upS, loS;
  logic [2:0]  baS;
  logic [12:0] addrS;

  ddfl_sync #(.W(25)) uSync (
    .clk  (clk),
    .nrst (nrst),
    .din  ({ck, cke, odt, csN, rasN, casN, weN, ba, addr, upperStrobePair, lowerStrobePair}),
    .dout (pinSync)
  );
  assign {ckS, ckeS, odtS, csNS, rasNS, casNS, weNS, baS, addrS, upS, loS} = pinSync;

  // ----------------------------------------
  // State
  // ----------------------------------------
  ddfl_pkg::ddfl_state_e state, next_state;
  logic [12:0] mr0, mr1, mr2, next_mr0, next_mr1, next_mr2;
  logic [15:0] lockCnt, next_lockCnt;
  logic        locking, next_locking, dllLocked, next_dllLocked;
  logic [7:0]  sreCnt, next_sreCnt;
  logic        clockIgnored, next_clockIgnored;
  logic        prevCk, prevCke, clUnsupported, next_clUnsupported;
  logic [ddfl_pkg::ERR_W-1:0] err, next_err, errSet;
  logic [1:0]  ctrl, next_ctrl;
  logic        waitReq, next_waitReq;
  logic [31:0] readData, next_readData;
  logic [15:0] next_dqOut;
  logic        next_dqOeN, next_strobeTerm, next_dqTerm;
  logic        ckRise, ckeFall, cmdValid, isMrs, isRef, busAck;
  logic        dllOff, wlMode, qoff, rttAny, rttNomEn;
  logic        upSample, loSample, upRise, loRise;

  assign dllOff   = mr1[ddfl_pkg::MR1_DLL_OFF];
  assign wlMode   = mr1[ddfl_pkg::MR1_WL];
  assign qoff     = mr1[ddfl_pkg::MR1_QOFF];
  assign rttNomEn = |(mr1 & ddfl_pkg::MR1_RTT_MASK);
  assign rttAny   = rttNomEn | (|(mr2 & ddfl_pkg::MR2_RTT_MASK));

  assign ckRise   = ckS & ~prevCk & ~clockIgnored;
  assign cmdValid = ckRise & ~csNS;
  assign isMrs    = cmdValid & ({rasNS, casNS, weNS} == ddfl_pkg::CMD_MRS) & ~baS[2];
  assign isRef    = cmdValid & ({rasNS, casNS, weNS} == ddfl_pkg::CMD_REF);
  assign ckeFall  = ckRise & prevCke & ~ckeS;

  // ----------------------------------------
  // Write-leveling lanes
  // ----------------------------------------
  // lanes leveled separately
  ddfl_wl_lane uLaneLo (
    .clk        (clk),
    .nrst       (nrst),
    .strobe     (loS),
    .ckLevel    (ckS),
    .enable     (wlMode),
    .sample     (loSample),
    .strobeRise (loRise)
  );
  ddfl_wl_lane uLaneUp (
    .clk        (clk),
    .nrst       (nrst),
    .strobe     (upS),
    .ckLevel    (ckS),
    .enable     (wlMode),
    .sample     (upSample),
    .strobeRise (upRise)
  );

  // ----------------------------------------
  // Device sequencing
  // ----------------------------------------
  always_comb begin
    next_state         = state;
    next_mr0           = mr0;
    next_mr1           = mr1;
    next_mr2           = mr2;
    next_lockCnt       = lockCnt;
    next_locking       = locking;
    next_dllLocked     = dllLocked;
    next_sreCnt        = sreCnt;
    next_clockIgnored  = clockIgnored;
    errSet             = '0;
    unique case (state)
      ddfl_pkg::ST_IDLE: begin
        if (ckeFall && isRef) begin
          next_state = ddfl_pkg::ST_SELF_REF;
        end else if (ckeFall) begin
          next_state = ddfl_pkg::ST_PWR_DN;
        end else if (isMrs) begin
          unique case (baS[1:0])
            2'h0: next_mr0 = addrS;
            2'h1: next_mr1 = addrS;
            2'h2: next_mr2 = addrS;
            default: ;
          endcase
          if (baS[1:0] == 2'h0 && addrS[ddfl_pkg::MR0_DLL_RST] && !dllOff) begin
            next_locking   = 1'b1;
            next_dllLocked = 1'b0;
            next_lockCnt   = '0;
          end
          if (baS[1:0] == 2'h1 && addrS[ddfl_pkg::MR1_DLL_OFF]) begin
            next_dllLocked = 1'b0;
            next_locking   = 1'b0;
          end
        end else if (cmdValid && wlMode && {rasNS, casNS, weNS} != ddfl_pkg::CMD_NOP) begin
          errSet[2] = 1'b1;
        end
      end
      ddfl_pkg::ST_SELF_REF: begin
        if (!clockIgnored && sreCnt < 8'(ddfl_pkg::TCKSRE_CYC)) begin
          next_sreCnt = sreCnt + 8'h01;
        end else begin
          next_clockIgnored = 1'b1;
        end
        if (ckeS) begin
          next_state        = ddfl_pkg::ST_IDLE;
          next_clockIgnored = 1'b0;
          next_sreCnt       = '0;
          next_dllLocked    = 1'b0;
          next_locking      = 1'b0;
        end
      end
      ddfl_pkg::ST_PWR_DN: begin
        if (ckRise && ckeS) begin
          next_state     = ddfl_pkg::ST_IDLE;
          next_dllLocked = 1'b0;
        end
      end
      default: next_state = ddfl_pkg::ST_IDLE;
    endcase
    if (locking && ckRise) begin
      next_lockCnt = lockCnt + 16'h0001;
      if (lockCnt == 16'(TDLLK - 1)) begin
        next_locking   = 1'b0;
        next_dllLocked = 1'b1;
      end
    end
    if (locking && state == ddfl_pkg::ST_IDLE) begin
      errSet[0] = ckRise & ~ckeS;
      errSet[1] = ckRise & odtS & rttAny;
    end
    next_clUnsupported = dllOff &&
      (((mr0 & ddfl_pkg::MR0_CL_MASK) != ddfl_pkg::MR0_CL6) ||
       ((mr2 & ddfl_pkg::MR2_CWL_MASK) != ddfl_pkg::MR2_CWL6));
  end

  // ----------------------------------------
  // Pin outputs and register bus
  // ----------------------------------------
  always_comb begin
    next_dqOut = ctrl[ddfl_pkg::CTRL_FB_ALL] ? {{8{upSample}}, {8{loSample}}}
                                              : {7'h00, upSample, 7'h00, loSample};
    next_dqOeN = ~(wlMode & ~qoff);
    next_strobeTerm = odtS & (wlMode | (rttNomEn & state != ddfl_pkg::ST_SELF_REF));
    // data termination follows ODT only if enabled
    next_dqTerm = odtS & ~wlMode & rttNomEn & state != ddfl_pkg::ST_SELF_REF;

    busAck        = (avsRead | avsWrite) & waitReq;
    next_waitReq  = ~busAck;
    next_readData = readData;
    next_ctrl     = ctrl;
    // Hardware set wins over software clear
    next_err      = err;
    if (busAck && avsWrite && avsByteenable[0]) begin
      if (avsAddress == ddfl_pkg::REG_CTRL) begin
        next_ctrl = avsWritedata[1:0];
      end else if (avsAddress == ddfl_pkg::REG_ERR) begin
        next_err = err & ~avsWritedata[ddfl_pkg::ERR_W-1:0];
      end
    end
    if (ctrl[ddfl_pkg::CTRL_ERR_EN]) begin
      next_err = next_err | errSet;
    end
    if (busAck && avsRead) begin
      unique case (avsAddress)
        ddfl_pkg::REG_CTRL:   next_readData = {30'h0, ctrl};
        ddfl_pkg::REG_STATUS: next_readData = {24'h0, clUnsupported, locking, clockIgnored,
                                               dllLocked, wlMode, dllOff, 2'(state)};
        ddfl_pkg::REG_ERR:    next_readData = {29'h0, err};
        ddfl_pkg::REG_MR0:    next_readData = {19'h0, mr0};
        ddfl_pkg::REG_MR1:    next_readData = {19'h0, mr1};
        ddfl_pkg::REG_MR2:    next_readData = {19'h0, mr2};
        default:              next_readData = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state         <= ddfl_pkg::ST_IDLE;
      mr0           <= ddfl_pkg::MR_RESET;
      mr1           <= ddfl_pkg::MR_RESET;
      mr2           <= ddfl_pkg::MR_RESET;
      lockCnt       <= '0;
      locking       <= 1'b0;
      dllLocked     <= 1'b0;
      sreCnt        <= '0;
      clockIgnored  <= 1'b0;
      prevCk        <= 1'b0;
      prevCke       <= 1'b0;
      clUnsupported <= 1'b0;
      err           <= '0;
      ctrl          <= ddfl_pkg::CTRL_RESET;
      waitReq       <= 1'b1;
      readData      <= 32'h0;
      dqOut         <= 16'h0;
      dqOeN         <= 1'b1;
      strobeTermOn  <= 1'b0;
      dqTermOn      <= 1'b0;
      dllLockedOut  <= 1'b0;
    end else begin
      state         <= next_state;
      mr0           <= next_mr0;
      mr1           <= next_mr1;
      mr2           <= next_mr2;
      lockCnt       <= next_lockCnt;
      locking       <= next_locking;
      dllLocked     <= next_dllLocked;
      sreCnt        <= next_sreCnt;
      clockIgnored  <= next_clockIgnored;
      prevCk        <= ckS;
      prevCke       <= ckRise ? ckeS : prevCke;
      clUnsupported <= next_clUnsupported;
      err           <= next_err;
      ctrl          <= next_ctrl;
      waitReq       <= next_waitReq;
      readData      <= next_readData;
      dqOut         <= next_dqOut;
      dqOeN         <= next_dqOeN;
      strobeTermOn  <= next_strobeTerm;
      dqTermOn      <= next_dqTerm;
      dllLockedOut  <= next_dllLocked;
    end
  end

  assign avsWaitrequest = waitReq;
  assign avsReaddata    = readData;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  bus_answer_a: assert property (@(posedge clk) disable iff (!nrst)
    (avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest ##1 avsWaitrequest)
    else $error("bus answer not one cycle after request");
  dll_off_bit_a: assert property (@(posedge clk) disable iff (!nrst)
    isMrs && baS[1:0] == 2'h1 && state == ddfl_pkg::ST_IDLE && !ckeFall |=> dllOff == $past(addrS[0]))
    else $error("DLL-off bit not taken from MRS");
  wl_enter_a: assert property (@(posedge clk) disable iff (!nrst)
    isMrs && baS[1:0] == 2'h1 && state == ddfl_pkg::ST_IDLE && !ckeFall |=> wlMode == $past(addrS[7]))
    else $error("leveling mode not taken from MRS");
  wl_sample_a: assert property (@(posedge clk) disable iff (!nrst)
    (loRise && wlMode ##1 wlMode) |=> loSample == $past(ckS, 2) && dqOut[0] == $past(ckS, 2))
    else $error("leveling feedback not the sampled clock");
  wl_sample_up_a: assert property (@(posedge clk) disable iff (!nrst)
    (upRise && wlMode ##1 wlMode) |=> upSample == $past(ckS, 2) && dqOut[8] == $past(ckS, 2))
    else $error("upper lane feedback not the sampled clock");
  lane_split_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl[0] && $stable(ctrl) |=> dqOut[15:8] == {8{$past(upSample)}} && dqOut[7:0] == {8{$past(loSample)}})
    else $error("byte lanes do not follow own strobe");
  strobe_term_a: assert property (@(posedge clk) disable iff (!nrst)
    wlMode && odtS |=> strobeTermOn && !dqTermOn)
    else $error("strobe termination missing in leveling");
  pd_term_a: assert property (@(posedge clk) disable iff (!nrst)
    state == ddfl_pkg::ST_PWR_DN && (!odtS || !rttNomEn) |=> !dqTermOn)
    else $error("termination on in power-down");
  clk_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
    clockIgnored && !ckeS |=> state == ddfl_pkg::ST_SELF_REF && $stable(mr1) && $stable(mr0))
    else $error("clock not ignored in self refresh");
  cl_check_a: assert property (@(posedge clk) disable iff (!nrst)
    dllOff && ((mr0 & ddfl_pkg::MR0_CL_MASK) != ddfl_pkg::MR0_CL6) |=> clUnsupported)
    else $error("unsupported latency not flagged");
  wl_feedback_c: cover property (@(posedge clk) disable iff (!nrst) wlMode && $rose(dqOut[0]));
  self_ref_c: cover property (@(posedge clk) disable iff (!nrst) $rose(clockIgnored));
  pwr_dn_c: cover property (@(posedge clk) disable iff (!nrst) state == ddfl_pkg::ST_PWR_DN);
  relock_c: cover property (@(posedge clk) disable iff (!nrst) $rose(dllLocked));
endmodule

// [dv/ddfl_ctrl_model.sv]
// Controller model: link clock, command pins, ODT and strobes.
// Assumes the bench calls one task at a time; clk is the system clock.
`timescale 1ns/1ps
module ddfl_ctrl_model (
  input  wire logic   clk,
  output logic        ck,
  output logic        cke,
  output logic        odt,
  output logic        csN,
  output logic        rasN,
  output logic        casN,
  output logic        weN,
  output logic [2:0]  ba,
  output logic [12:0] addr,
  output logic        upperStrobePair,
  output logic        lowerStrobePair
);
  bit  ckRun  = 1'h1;
  real ckHalf = 62.5;
  // ----------------
  // Link clock
  // ----------------
  // period only changes while stopped
  initial begin
    ck = 1'h0;
    forever begin
      #(ckHalf);
      ck = ckRun ? ~ck : 1'h0;
    end
  end
  // ODT low, CKE high at rest
  initial begin
    {cke, csN, rasN, casN, weN} = 5'h1F;
    odt = 1'h0;
    ba = 3'h0;
    addr = 13'h0;
    {upperStrobePair, lowerStrobePair} = 2'h0;
  end
  // ----------------
  // Sequencing tasks
  // ----------------
  // NOP between steps, address bus scrambled when unused
  task automatic cmd(input logic k, input logic [2:0] c, input logic [2:0] b, input logic [12:0] a);
    @(negedge ck);
    @(posedge clk);
    cke <= k;
    csN <= 1'h0;
    {rasN, casN, weN} <= c;
    ba <= b;
    addr <= a;
    @(negedge ck);
    @(posedge clk);
    {rasN, casN, weN} <= ddfl_pkg::CMD_NOP;
    addr <= ~a;
  endtask
  task automatic mrs(input logic [2:0] b, input logic [12:0] a);
    cmd(1'h1, ddfl_pkg::CMD_MRS, b, a);
  endtask
  // stop after tCKSRE; stable tCKSRX before exit
  task automatic freq(input real h);
    repeat (2) @(posedge clk);
    ckRun = 1'h0;
    #300;
    ckHalf = h;
    ckRun = 1'h1;
    repeat (5) @(posedge ck);
  endtask
  // one strobe edge placed in a chosen clock phase
  task automatic pulse(input logic up, input logic lvl);
    if (lvl) @(posedge ck);
    else @(negedge ck);
    repeat (3) @(posedge clk);
    if (up) upperStrobePair <= 1'h1;
    else lowerStrobePair <= 1'h1;
    repeat (8) @(posedge clk);
    {upperStrobePair, lowerStrobePair} <= 2'h0;
  endtask
endmodule

// [dv/ddfl_top_tb.sv]
// Self-checking bench: Avalon register access and controller sequences.
// Assumes a lock count of 8; bus tasks wait on waitrequest, not on a cycle count.
`timescale 1ns/1ps
module ddfl_top_tb;
  logic        clk;
  logic        nrst;
  logic [4:0]  avsAddress;
  logic        avsRead;
  logic        avsWrite;
  logic [31:0] avsWritedata;
  logic [3:0]  avsByteenable;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic        ck;
  logic        cke;
  logic        odt;
  logic        csN;
  logic        rasN;
  logic        casN;
  logic        weN;
  logic [2:0]  ba;
  logic [12:0] addr;
  logic        upperStrobePair;
  logic        lowerStrobePair;
  logic [15:0] dqOut;
  logic        dqOeN;
  logic        strobeTermOn;
  logic        dqTermOn;
  logic        dllLockedOut;
  logic [31:0] d;
  int          mismatches = 0;
  int          cmp_count = 0;

  ddfl_top #(.TDLLK(8)) i_ddfl_top (.*);
  ddfl_ctrl_model i_ddfl_ctrl_model (.*);

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ----------------
  // Helpers
  // ----------------
  function automatic logic [31:0] pins();
    return {11'h0, avsWaitrequest, dqOeN, strobeTermOn, dqTermOn, dllLockedOut, dqOut};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    // Callers may return on a link clock edge; realign to clk first
    @(posedge clk);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= ~w;
    avsWritedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'h0 && n < 20);
    rd = avsReaddata;
    chk({31'h0, avsWaitrequest}, 32'h0);
    avsWrite <= 1'h0;
    avsRead <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0, d);
    chk(d, exp);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    bus(1'h1, a, v, d);
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Hang guard, far beyond the expected run of about fifteen microseconds
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end
  // ----------------
  // Tests
  // ----------------
  initial begin
    nrst = 1'h0;
    {avsAddress, avsRead, avsWrite, avsWritedata} = 39'h0;
    avsByteenable = 4'hF;
    repeat (4) @(posedge clk);
    chk(pins(), 32'h00180000);
    nrst <= 1'h1;
    for (int i = 0; i < 8; i++) rdc(5'(4 * i), 32'h0);
    avsByteenable <= 4'hE;
    wr(ddfl_pkg::REG_CTRL, 32'h3);
    rdc(ddfl_pkg::REG_CTRL, 32'h0);
    avsByteenable <= 4'hF;
    wr(ddfl_pkg::REG_STATUS, 32'hFF);
    rdc(ddfl_pkg::REG_STATUS, 32'h0);
    wr(ddfl_pkg::REG_MR1, 32'h1);
    rdc(ddfl_pkg::REG_MR1, 32'h0);
    i_ddfl_ctrl_model.mrs(3'h1, 13'h0001);
    rdc(ddfl_pkg::REG_MR1, 32'h1);
    rdc(ddfl_pkg::REG_STATUS, 32'h84);
    i_ddfl_ctrl_model.mrs(3'h0, ddfl_pkg::MR0_CL6);
    i_ddfl_ctrl_model.mrs(3'h2, ddfl_pkg::MR2_CWL6);
    rdc(ddfl_pkg::REG_STATUS, 32'h04);
    repeat (12) @(posedge ck);
    i_ddfl_ctrl_model.cmd(1'h0, ddfl_pkg::CMD_REF, 3'h0, 13'h0);
    rdc(ddfl_pkg::REG_STATUS, 32'h25);
    i_ddfl_ctrl_model.freq(80.0);
    i_ddfl_ctrl_model.cmd(1'h1, ddfl_pkg::CMD_NOP, 3'h0, 13'h0);
    rdc(ddfl_pkg::REG_STATUS, 32'h04);
    repeat (8) @(posedge ck);
    i_ddfl_ctrl_model.cmd(1'h0, ddfl_pkg::CMD_REF, 3'h0, 13'h0);
    i_ddfl_ctrl_model.freq(62.5);
    i_ddfl_ctrl_model.cmd(1'h1, ddfl_pkg::CMD_NOP, 3'h0, 13'h0);
    repeat (8) @(posedge ck);
    i_ddfl_ctrl_model.mrs(3'h1, 13'h0);
    rdc(ddfl_pkg::REG_STATUS, 32'h00);
    repeat (4) @(posedge ck);
    i_ddfl_ctrl_model.mrs(3'h0, 13'h0100);
    rdc(ddfl_pkg::REG_STATUS, 32'h40);
    repeat (10) @(posedge ck);
    rdc(ddfl_pkg::REG_STATUS, 32'h10);
    chk({31'h0, dllLockedOut}, 32'h1);
    i_ddfl_ctrl_model.cmd(1'h0, ddfl_pkg::CMD_NOP, 3'h0, 13'h0);
    bus(1'h0, ddfl_pkg::REG_STATUS, 32'h0, d);
    chk(d & 32'h3, 32'h2);
    i_ddfl_ctrl_model.freq(62.5);
    i_ddfl_ctrl_model.cmd(1'h1, ddfl_pkg::CMD_NOP, 3'h0, 13'h0);
    rdc(ddfl_pkg::REG_STATUS, 32'h00);
    i_ddfl_ctrl_model.mrs(3'h1, 13'h0080);
    rdc(ddfl_pkg::REG_STATUS, 32'h08);
    i_ddfl_ctrl_model.odt <= 1'h1;
    repeat (6) @(posedge clk);
    chk(pins() & 32'h1F0000, 32'h140000);
    i_ddfl_ctrl_model.pulse(1'h0, 1'h1);
    chk(pins(), 32'h140001);
    i_ddfl_ctrl_model.pulse(1'h1, 1'h0);
    chk(pins(), 32'h140001);
    i_ddfl_ctrl_model.pulse(1'h1, 1'h1);
    chk(pins(), 32'h140101);
    wr(ddfl_pkg::REG_CTRL, 32'h3);
    i_ddfl_ctrl_model.pulse(1'h0, 1'h0);
    i_ddfl_ctrl_model.pulse(1'h1, 1'h1);
    chk(pins(), 32'h14FF00);
    i_ddfl_ctrl_model.cmd(1'h1, ddfl_pkg::CMD_REF, 3'h0, 13'h0);
    rdc(ddfl_pkg::REG_ERR, 32'h4);
    wr(ddfl_pkg::REG_ERR, 32'h4);
    rdc(ddfl_pkg::REG_ERR, 32'h0);
    i_ddfl_ctrl_model.odt <= 1'h0;
    i_ddfl_ctrl_model.mrs(3'h1, 13'h0);
    repeat (4) @(posedge clk);
    chk(pins(), 32'h180000);
    rdc(ddfl_pkg::REG_STATUS, 32'h00);
    i_ddfl_ctrl_model.mrs(3'h1, 13'h0004);
    i_ddfl_ctrl_model.odt <= 1'h1;
    repeat (6) @(posedge clk);
    chk(pins() & 32'h1F0000, 32'h1E0000);
    i_ddfl_ctrl_model.mrs(3'h0, 13'h0100);
    repeat (2) @(posedge ck);
    rdc(ddfl_pkg::REG_ERR, 32'h2);
    i_ddfl_ctrl_model.odt <= 1'h0;
    i_ddfl_ctrl_model.cmd(1'h0, ddfl_pkg::CMD_NOP, 3'h0, 13'h0);
    rdc(ddfl_pkg::REG_ERR, 32'h3);
    i_ddfl_ctrl_model.cmd(1'h1, ddfl_pkg::CMD_NOP, 3'h0, 13'h0);
    end_of_test();
  end
endmodule
